// *** shared/hti_cfg.svh ***
`ifndef HTI_CFG_SVH
`define HTI_CFG_SVH
// Behaviour
// (RULE_01) no-wait mode: NACK address until conversion done
// (RULE_02) stretch mode: write cmd, Sr, read MS LS
// (RULE_03) no-wait mode: host repeats read address until ACK; host does so after F5/F3 only, a voltage NACK sets err
// (RULE_04) humidity code low bits always 10
// (RULE_05) host: RH = 125*code/65536 - 6, clamped
// (RULE_06) humidity conversion also captures temperature
// (RULE_07) read-previous-temperature starts no conversion
// (RULE_08) previous temperature: two bytes, no checksum
// (RULE_09) temperature commands run fresh temperature conversion
// (RULE_10) temperature code low bits always 00
// (RULE_11) host: T = 175.72*code/65536 - 46.85
// (RULE_12) three user registers, never a checksum
// (RULE_13) register read: cmd, Sr, read one byte
// (RULE_14) register write: cmd, data byte, all acked
// (RULE_15) voltage result is signed 16-bit code
// (RULE_16) voltage result never carries a checksum
// (RULE_17) checksum only when host acks low byte
// (RULE_18) checksum CRC-8 poly 0x31, init zero
// (RULE_19) humidity command code picks the wait mode
// (RULE_20) stretch mode holds SCL low while converting
// (RULE_21) previous temperature undefined before humidity conversion

`define HTI_ADDR_HI    6'h20
`define HTI_RD_BIT     1'h1
`define HTI_WR_BIT     1'h0
`define HTI_BITS       4'h8
`define HTI_C_RH_HOLD  8'hE5
`define HTI_C_RH_POLL  8'hF5
`define HTI_C_T_HOLD   8'hE3
`define HTI_C_T_POLL   8'hF3
`define HTI_C_VOLT     8'hEE
`define HTI_C_PREV_T   8'hE0
`define HTI_C_RESET    8'hFE
`define HTI_C_WR_U1    8'hE6
`define HTI_C_RD_U1    8'hE7
`define HTI_C_WR_U2    8'h50
`define HTI_C_RD_U2    8'h10
`define HTI_C_WR_U3    8'h51
`define HTI_C_RD_U3    8'h11
`define HTI_U1_RST     8'h00
`define HTI_U2_RST     8'h00
`define HTI_U3_RST     8'h00
`define HTI_U2_POLL    6
`define HTI_HUM_LSB    2'h2
`define HTI_TMP_LSB    2'h0
`define HTI_CRC_POLY   8'h31
`define HTI_CRC_INIT   8'h00
`define HTI_CLK_NS     10
`define HTI_CONV_NS    20000
`define HTI_QTR_NS     2500
`define HTI_RH_MUL     24'h00007D
`define HTI_RH_OFS     8'h06
`define HTI_RH_MAX     8'h64
`define HTI_T_MUL      32'h000044A4
`define HTI_T_OFS      16'h124D
`endif

// *** shared/hti_pkg.sv ***
package hti_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ADDR = 3'b001, D_AACK = 3'b010, D_RX = 3'b011,
    D_RACK = 3'b100, D_TX   = 3'b101, D_TACK = 3'b110, D_STR = 3'b111
  } hti_dst_t;
  typedef enum logic [1:0] {
    K_HUM = 2'b00, K_TMP = 2'b01, K_VOLT = 2'b10
  } hti_kind_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11
  } hti_hst_t;
  typedef enum logic [2:0] {
    S_ADDRW = 3'b000, S_CMD = 3'b001, S_DATA = 3'b010,
    S_ADDRR = 3'b011, S_RD  = 3'b100
  } hti_step_t;
  typedef enum logic [1:0] {
    OP_MEAS = 2'b00, OP_RREG = 2'b01, OP_WREG = 2'b10
  } hti_op_t;
  typedef struct packed {
    logic            scl1, scl2, sclp, sda1, sda2, sdap, ad1, ad2;
    hti_dst_t        st;
    logic [3:0]      bitc;
    logic [7:0]      sh;
    logic            rw, wph, regrd, busy, nohold;
    logic [1:0]      widx, ridx, len, idx;
    hti_kind_t       kind;
    logic [15:0]     cnt, res, tprev;
    logic [2:0][7:0] usr;
    logic            scl_oe_n, sda_oe_n, pin;
  } hti_dev_t;
  typedef struct packed {
    logic        scl1, scl2, sda1, sda2;
    hti_hst_t    st;
    hti_step_t   step;
    hti_op_t     op;
    logic [1:0]  ph, rcnt, nneed;
    logic [15:0] tick;
    logic [7:0]  sh, cmd, wd;
    logic [3:0]  bitc;
    logic [6:0]  addr;
    logic        nak, nohold, busy, done, err;
    logic [23:0] rd;
    logic [7:0]  rh;
    logic [15:0] tc;
    logic        scl_oe_n, sda_oe_n, pin;
  } hti_host_t;
endpackage

// *** shared/hti_bus_if.sv ***
`timescale 1ns/1ps
interface hti_bus_if;
  logic h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n;
  logic d_scl_o, d_scl_oe_n, d_sda_o, d_sda_oe_n;
  logic scl, sda;
  // wired-AND with pull-up: a line is low if any enabled driver pulls it
  assign scl = (h_scl_oe_n | h_scl_o) & (d_scl_oe_n | d_scl_o);
  assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
  modport host (input scl, sda,
                output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n);
  modport dev  (input scl, sda,
                output d_scl_o, d_scl_oe_n, d_sda_o, d_sda_oe_n);
endinterface // hti_bus_if

// *** rtl/hti_dev.sv ***
`timescale 1ns/1ps
`include "hti_cfg.svh"
module hti_dev
  import hti_pkg::*;
#(
  parameter int CONV_CYC = `HTI_CONV_NS / `HTI_CLK_NS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  hti_bus_if.dev           bus,
  input  wire logic        i_addr_lsb,
  input  wire logic [15:0] i_hum_raw,
  input  wire logic [15:0] i_temp_raw,
  input  wire logic [15:0] i_volt_raw,
  output logic             o_conv_busy,
  output logic [7:0]       o_usr1,
  output logic [7:0]       o_usr2,
  output logic [7:0]       o_usr3
);
  hti_dev_t r;
  hti_dev_t n;
  logic     rise, fall, start, stop;

  // ****************************************
  // checksum and byte selection
  // ****************************************
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = `HTI_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'h0} ^ `HTI_CRC_POLY; // see RULE_18
      end else begin
        c = {c[6:0], 1'h0};
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] tx_byte(input hti_dev_t s);
    logic [7:0] b;
    case (s.idx)
      2'h0: b = s.regrd ? s.usr[s.ridx] : s.res[15:8];
      2'h1: b = s.res[7:0];
      default: b = crc8(s.res);
    endcase
    return b;
  endfunction

  // ****************************************
  // bus conditions from synchronised pins
  // ****************************************
  always_comb begin
    rise  = r.scl2 & ~r.sclp;
    fall  = ~r.scl2 & r.sclp;
    start = r.scl2 & r.sclp & r.sdap & ~r.sda2;
    stop  = r.scl2 & r.sclp & ~r.sdap & r.sda2;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    n.scl1 = bus.scl;
    n.scl2 = r.scl1;
    n.sclp = r.scl2;
    n.sda1 = bus.sda;
    n.sda2 = r.sda1;
    n.sdap = r.sda2;
    n.ad1  = i_addr_lsb;
    n.ad2  = r.ad1;
    // conversion timer; raw samples taken at the end of conversion
    if (r.busy) begin
      if (r.cnt == 16'h0000) begin
        n.busy = 1'h0;
        case (r.kind)
          K_HUM: begin
            n.res   = {i_hum_raw[15:2], `HTI_HUM_LSB};  // see RULE_04
            n.tprev = {i_temp_raw[15:2], `HTI_TMP_LSB}; // see RULE_06
          end
          K_TMP: n.res = {i_temp_raw[15:2], `HTI_TMP_LSB}; // see RULE_10
          default: n.res = i_volt_raw; // see RULE_15
        endcase
      end else begin
        n.cnt = r.cnt - 16'h0001;
      end
    end
    if (start) begin
      n.st       = D_ADDR;
      n.bitc     = 4'h0;
      n.sda_oe_n = 1'h1;
    end else if (stop) begin
      n.st       = D_IDLE;
      n.sda_oe_n = 1'h1;
      n.scl_oe_n = 1'h1;
    end else begin
      case (r.st)
        D_ADDR: begin
          if (rise) begin
            n.sh   = {r.sh[6:0], r.sda2};
            n.bitc = r.bitc + 4'h1;
          end else if (fall && r.bitc == `HTI_BITS) begin
            n.rw  = r.sh[0];
            n.idx = 2'h0;
            if (r.sh[7:1] != {`HTI_ADDR_HI, r.ad2}) begin
              n.st = D_IDLE;
            end else if (r.sh[0] && r.busy && r.nohold) begin
              n.st = D_IDLE; // see RULE_01
            end else if (r.sh[0] && r.busy) begin
              n.st       = D_STR;
              n.scl_oe_n = 1'h0; // see RULE_20
            end else begin
              n.st       = D_AACK;
              n.sda_oe_n = 1'h0;
            end
          end
        end
        D_STR: begin
          // ack goes out a cycle before scl is let go, so data never
          // moves in the same step as the clock edge
          if (!r.busy) begin
            n.sda_oe_n = 1'h0;
            if (!r.sda_oe_n) begin
              n.scl_oe_n = 1'h1; // see RULE_20
              n.st       = D_AACK;
            end
          end
        end
        D_AACK: begin
          if (fall) begin
            n.bitc = 4'h0;
            if (r.rw) begin
              n.sh       = tx_byte(r); // see RULE_02
              n.sda_oe_n = n.sh[7];
              n.st       = D_TX;
            end else begin
              n.sda_oe_n = 1'h1;
              n.st       = D_RX;
            end
          end
        end
        D_RX: begin
          if (rise) begin
            n.sh   = {r.sh[6:0], r.sda2};
            n.bitc = r.bitc + 4'h1;
          end else if (fall && r.bitc == `HTI_BITS) begin
            n.sda_oe_n = 1'h0; // see RULE_14
            n.st       = D_RACK;
            if (r.wph) begin
              n.usr[r.widx] = r.sh; // see RULE_14
              n.wph         = 1'h0;
            end else begin
              n.regrd = 1'h0;
              case (r.sh)
                `HTI_C_RH_HOLD, `HTI_C_RH_POLL: begin
                  n.busy   = 1'h1;
                  n.kind   = K_HUM;
                  n.nohold = (r.sh == `HTI_C_RH_POLL); // see RULE_19
                  n.len    = 2'h3;
                  n.cnt    = 16'(CONV_CYC - 1);
                end
                `HTI_C_T_HOLD, `HTI_C_T_POLL: begin
                  n.busy   = 1'h1; // see RULE_09
                  n.kind   = K_TMP;
                  n.nohold = (r.sh == `HTI_C_T_POLL);
                  n.len    = 2'h3;
                  n.cnt    = 16'(CONV_CYC - 1);
                end
                `HTI_C_VOLT: begin
                  n.busy   = 1'h1;
                  n.kind   = K_VOLT;
                  n.nohold = r.usr[1][`HTI_U2_POLL];
                  n.len    = 2'h2; // see RULE_16
                  n.cnt    = 16'(CONV_CYC - 1);
                end
                `HTI_C_PREV_T: begin
                  // tprev is whatever reset left until a humidity run
                  n.res = r.tprev; // see RULE_07, RULE_21
                  n.len = 2'h2;    // see RULE_08
                end
                `HTI_C_RD_U1, `HTI_C_RD_U2, `HTI_C_RD_U3: begin
                  n.regrd = 1'h1;
                  n.len   = 2'h1; // see RULE_12, RULE_13
                  n.ridx  = (r.sh == `HTI_C_RD_U1) ? 2'h0 :
                            (r.sh == `HTI_C_RD_U2) ? 2'h1 : 2'h2;
                end
                `HTI_C_WR_U1, `HTI_C_WR_U2, `HTI_C_WR_U3: begin
                  n.wph  = 1'h1;
                  n.widx = (r.sh == `HTI_C_WR_U1) ? 2'h0 :
                           (r.sh == `HTI_C_WR_U2) ? 2'h1 : 2'h2;
                end
                `HTI_C_RESET: begin
                  n.usr = {`HTI_U3_RST, `HTI_U2_RST, `HTI_U1_RST};
                end
                default: n.regrd = 1'h0;
              endcase
            end
          end
        end
        D_RACK: begin
          if (fall) begin
            n.sda_oe_n = 1'h1;
            n.bitc     = 4'h0;
            n.st       = D_RX;
          end
        end
        D_TX: begin
          if (rise) begin
            n.bitc = r.bitc + 4'h1;
          end else if (fall) begin
            if (r.bitc == `HTI_BITS) begin
              n.sda_oe_n = 1'h1;
              n.st       = D_TACK;
            end else begin
              n.sh       = {r.sh[6:0], 1'h0};
              n.sda_oe_n = r.sh[6];
            end
          end
        end
        D_TACK: begin
          if (rise) begin
            // checksum byte only follows an acked low byte
            if (!r.sda2 && (r.idx + 2'h1) < r.len) begin
              n.idx = r.idx + 2'h1; // see RULE_17
              n.st  = D_AACK;
            end else begin
              n.st = D_IDLE; // see RULE_17
            end
          end
        end
        default: n.st = D_IDLE;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r          <= '0;
      r.scl1     <= 1'h1;
      r.scl2     <= 1'h1;
      r.sclp     <= 1'h1;
      r.sda1     <= 1'h1;
      r.sda2     <= 1'h1;
      r.sdap     <= 1'h1;
      r.len      <= 2'h2;
      r.usr      <= {`HTI_U3_RST, `HTI_U2_RST, `HTI_U1_RST};
      r.scl_oe_n <= 1'h1;
      r.sda_oe_n <= 1'h1;
    end else begin
      r <= n;
    end
  end

  assign bus.d_scl_o    = r.pin;
  assign bus.d_sda_o    = r.pin;
  assign bus.d_scl_oe_n = r.scl_oe_n;
  assign bus.d_sda_oe_n = r.sda_oe_n;
  assign o_conv_busy    = r.busy;
  assign o_usr1         = r.usr[0];
  assign o_usr2         = r.usr[1];
  assign o_usr3         = r.usr[2];
endmodule // hti_dev

// *** rtl/hti_host.sv ***
`timescale 1ns/1ps
`include "hti_cfg.svh"
module hti_host
  import hti_pkg::*;
#(
  parameter int QTR_CYC = `HTI_QTR_NS / `HTI_CLK_NS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  hti_bus_if.host          bus,
  input  wire logic        i_go,
  input  hti_op_t          i_op,
  input  wire logic [7:0]  i_cmd,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_addr_lsb,
  input  wire logic        i_want_crc,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_err,
  output logic [23:0]      o_rdata,
  output logic [7:0]       o_rh_pct,
  output logic [15:0]      o_temp_cc
);
  hti_host_t   r;
  hti_host_t   n;
  logic        adv;
  logic [15:0] code;
  logic [23:0] rh_p;
  logic [31:0] t_p;

  always_comb begin
    n      = r;
    n.scl1 = bus.scl;
    n.scl2 = r.scl1;
    n.sda1 = bus.sda;
    n.sda2 = r.sda1;
    n.done = 1'h0;
    // phase 2 waits for scl to read high, which honours stretching
    adv  = (r.tick == 16'(QTR_CYC - 1)) && (r.ph != 2'h2 || r.scl2);
    code = (r.nneed == 2'h3) ? r.rd[23:8] : r.rd[15:0];
    rh_p = 24'(code) * `HTI_RH_MUL;
    t_p  = 32'(code) * `HTI_T_MUL;
    if (r.st != H_IDLE && r.tick != 16'(QTR_CYC - 1)) begin
      n.tick = r.tick + 16'h0001;
    end else if (adv) begin
      n.tick = 16'h0000;
      n.ph   = r.ph + 2'h1;
    end
    case (r.st)
      H_IDLE: begin
        n.tick = 16'h0000;
        n.ph   = 2'h0;
        if (i_go) begin
          n.busy   = 1'h1;
          n.err    = 1'h0;
          n.rd     = 24'h000000;
          n.op     = i_op;
          n.cmd    = i_cmd;
          n.wd     = i_wdata;
          n.addr   = {`HTI_ADDR_HI, i_addr_lsb};
          n.nohold = (i_cmd == `HTI_C_RH_POLL) ||
                     (i_cmd == `HTI_C_T_POLL);
          n.nneed  = (i_op == OP_RREG) ? 2'h1 :
                     (i_want_crc && i_cmd != `HTI_C_PREV_T &&
                      i_cmd != `HTI_C_VOLT) ? 2'h3 : 2'h2; // see RULE_08
          n.step   = S_ADDRW;
          n.st     = H_START;
        end
      end
      H_START: if (adv) begin
        case (r.ph)
          2'h0: n.sda_oe_n = 1'h1;
          2'h1: n.scl_oe_n = 1'h1;
          2'h2: n.sda_oe_n = 1'h0;
          default: begin
            n.scl_oe_n = 1'h0;
            n.sh   = {r.addr, (r.step == S_ADDRW) ? `HTI_WR_BIT
                                                  : `HTI_RD_BIT};
            n.bitc = 4'h0;
            n.st   = H_BIT;
          end
        endcase
      end
      H_BIT: if (adv) begin
        case (r.ph)
          2'h0: begin
            if (r.bitc == `HTI_BITS) begin
              // ack a read byte only when more bytes are wanted
              n.sda_oe_n = !(r.step == S_RD &&
                             (r.rcnt + 2'h1) < r.nneed); // see RULE_17
            end else begin
              n.sda_oe_n = (r.step == S_RD) ? 1'h1 : r.sh[7];
            end
          end
          2'h1: n.scl_oe_n = 1'h1;
          2'h2: begin
            if (r.bitc == `HTI_BITS) begin
              n.nak = r.sda2;
            end else if (r.step == S_RD) begin
              n.sh = {r.sh[6:0], r.sda2};
            end else begin
              n.sh = {r.sh[6:0], 1'h0};
            end
          end
          default: begin
            n.scl_oe_n = 1'h0;
            n.bitc     = r.bitc + 4'h1;
            if (r.bitc == `HTI_BITS) begin
              n.bitc = 4'h0;
              n.st   = H_STOP;
              case (r.step)
                S_ADDRW: if (!r.nak) begin
                  n.step = S_CMD;
                  n.sh   = r.cmd;
                  n.st   = H_BIT;
                end
                S_CMD: if (!r.nak) begin
                  if (r.op == OP_WREG) begin
                    n.step = S_DATA; // see RULE_14
                    n.sh   = r.wd;
                    n.st   = H_BIT;
                  end else begin
                    n.step = S_ADDRR; // see RULE_02, RULE_13
                    n.st   = H_START;
                  end
                end
                S_DATA: n.st = H_STOP;
                S_ADDRR: begin
                  if (!r.nak) begin
                    n.step = S_RD;
                    n.rcnt = 2'h0;
                    n.st   = H_BIT;
                  end else if (r.nohold) begin
                    n.st = H_START; // see RULE_03
                  end
                end
                default: begin
                  n.rd   = {r.rd[15:0], r.sh};
                  n.rcnt = r.rcnt + 2'h1;
                  if ((r.rcnt + 2'h1) < r.nneed) begin
                    n.st = H_BIT;
                  end
                end
              endcase
              if (r.nak && r.step != S_RD && r.step != S_DATA &&
                  !(r.step == S_ADDRR && r.nohold)) begin
                n.err = 1'h1;
              end
              if (r.nak && r.step == S_DATA) begin
                n.err = 1'h1;
              end
            end
          end
        endcase
      end
      default: if (adv) begin
        case (r.ph)
          2'h0: n.sda_oe_n = 1'h0;
          2'h1: n.scl_oe_n = 1'h1;
          2'h2: n.sda_oe_n = 1'h1;
          default: begin
            n.st   = H_IDLE;
            n.busy = 1'h0;
            n.done = 1'h1;
            // RH clamped to 0..100, temperature in 0.01 degC
            if (rh_p[23:16] < `HTI_RH_OFS) begin
              n.rh = 8'h00; // see RULE_05
            end else if (rh_p[23:16] - `HTI_RH_OFS > `HTI_RH_MAX) begin
              n.rh = `HTI_RH_MAX;
            end else begin
              n.rh = rh_p[23:16] - `HTI_RH_OFS;
            end
            n.tc = t_p[31:16] - `HTI_T_OFS; // see RULE_11
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r          <= '0;
      r.scl1     <= 1'h1;
      r.scl2     <= 1'h1;
      r.sda1     <= 1'h1;
      r.sda2     <= 1'h1;
      r.scl_oe_n <= 1'h1;
      r.sda_oe_n <= 1'h1;
    end else begin
      r <= n;
    end
  end

  assign bus.h_scl_o    = r.pin;
  assign bus.h_sda_o    = r.pin;
  assign bus.h_scl_oe_n = r.scl_oe_n;
  assign bus.h_sda_oe_n = r.sda_oe_n;
  assign o_busy         = r.busy;
  assign o_done         = r.done;
  assign o_err          = r.err;
  assign o_rdata        = r.rd;
  assign o_rh_pct       = r.rh;
  assign o_temp_cc      = r.tc;
endmodule // hti_host

// *** sim/hti_bus_monitor.sv ***
`timescale 1ns/1ps
module hti_bus_monitor #(
  parameter int CONV_CYC = 2000
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic h_scl_oe_n,
  input  wire logic h_sda_oe_n,
  input  wire logic d_scl_oe_n,
  input  wire logic d_sda_oe_n,
  input  wire logic o_conv_busy
);
  // ********************************************
  // helper counters
  // ********************************************
  logic [15:0] busy_cnt_r;
  logic [3:0]  idle_cnt_r;

  // idle count saturates so a long quiet spell never wraps to "just ended"
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt_r <= 16'h0000;
      idle_cnt_r <= 4'hF;
    end else begin
      busy_cnt_r <= o_conv_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
      idle_cnt_r <= o_conv_busy ? 4'h0 :
                    ((idle_cnt_r == 4'hF) ? 4'hF : idle_cnt_r + 4'h1);
    end
  end

  // ********************************************
  // wire checks
  // ********************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_reset_all_released: assert property ($rose(i_rst_n) |->
    d_scl_oe_n && d_sda_oe_n && h_scl_oe_n && h_sda_oe_n)
    else $error("bus driven right after reset release");
  a_stretch_while_busy: assert property (
    !d_scl_oe_n |-> o_conv_busy || (idle_cnt_r < 4'h8))
    else $error("device holds clock low with no conversion running");
  a_stretch_release: assert property (
    $fell(o_conv_busy) |-> ##[0:8] d_scl_oe_n)
    else $error("clock not released after conversion end");
  a_stretch_pulls_low: assert property (
    !d_scl_oe_n |-> !scl)
    else $error("stretched clock line not low");
  a_stretch_from_low: assert property (
    $fell(d_scl_oe_n) |-> !$past(scl))
    else $error("device pulled clock low while it was high");
  a_nack_busy: assert property (
    (busy_cnt_r > 16'h0064) |-> d_sda_oe_n)
    else $error("device drove data low during conversion");
  a_sda_stable_high: assert property (
    scl && $past(scl) |-> $stable(d_sda_oe_n))
    else $error("device changed data while clock high");
  a_start_by_host: assert property (
    $fell(sda) && scl |-> d_sda_oe_n)
    else $error("device made a start condition");
endmodule // hti_bus_monitor

// *** sim/humidity_temp_i2c_readout_tb.sv ***
`timescale 1ns/1ps
module humidity_temp_i2c_readout_tb
  import hti_pkg::*;
;
  // ********************************************
  // signals and instances
  // ********************************************
  // conversion outlasts Sr plus read address: stretch and polling happen
  localparam int CONV = 2000;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        go;
  logic        want_crc;
  logic        busy;
  logic        done;
  logic        err;
  logic        conv_busy;
  hti_op_t     op;
  logic [7:0]  cmd;
  logic [7:0]  wdata;
  logic [7:0]  rh_pct;
  logic [7:0]  usr1;
  logic [7:0]  usr2;
  logic [7:0]  usr3;
  logic [15:0] hum;
  logic [15:0] temp;
  logic [15:0] volt;
  logic [15:0] temp_cc;
  logic [23:0] rdata;
  logic [7:0]  wcmd [3] = '{8'hE6, 8'h50, 8'h51};
  logic [7:0]  rcmd [3] = '{8'hE7, 8'h10, 8'h11};
  logic [7:0]  wval [3] = '{8'h5A, 8'h25, 8'hC3};
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 core_clk = ~core_clk;

  hti_bus_if i_hti_bus_if ();

  hti_dev #(.CONV_CYC(CONV)) i_hti_dev (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .bus(i_hti_bus_if),
    .i_addr_lsb(1'b0), .i_hum_raw(hum), .i_temp_raw(temp),
    .i_volt_raw(volt), .o_conv_busy(conv_busy),
    .o_usr1(usr1), .o_usr2(usr2), .o_usr3(usr3));

  // short quarter keeps the run small but well above the sync latency
  hti_host #(.QTR_CYC(20)) i_hti_host (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .bus(i_hti_bus_if),
    .i_go(go), .i_op(op), .i_cmd(cmd), .i_wdata(wdata),
    .i_addr_lsb(1'b0), .i_want_crc(want_crc), .o_busy(busy),
    .o_done(done), .o_err(err), .o_rdata(rdata),
    .o_rh_pct(rh_pct), .o_temp_cc(temp_cc));

  hti_bus_monitor #(.CONV_CYC(CONV)) i_hti_bus_monitor (
    .i_core_clk(core_clk), .i_rst_n(rst_n),
    .scl(i_hti_bus_if.scl), .sda(i_hti_bus_if.sda),
    .h_scl_oe_n(i_hti_bus_if.h_scl_oe_n),
    .h_sda_oe_n(i_hti_bus_if.h_sda_oe_n),
    .d_scl_oe_n(i_hti_bus_if.d_scl_oe_n),
    .d_sda_oe_n(i_hti_bus_if.d_sda_oe_n),
    .o_conv_busy(conv_busy));

  // ********************************************
  // tasks
  // ********************************************
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input hti_op_t o, input logic [7:0] c, w,
                      input logic crc);
    int n;
    @(negedge core_clk);
    op = o;
    cmd = c;
    wdata = w;
    want_crc = crc;
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    chk("done", {23'h000000, done}, 24'h000001);
    chk("err", {23'h000000, err}, 24'h000000);
    chk("busy", {23'h000000, busy}, 24'h000000);
  endtask

  // independent checksum: msb first, zero start
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      test_done();
    end
  end

  // ********************************************
  // test sequence
  // ********************************************
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    op = OP_MEAS;
    cmd = 8'h00;
    wdata = 8'h00;
    want_crc = 1'b0;
    hum = 16'h0000;
    temp = 16'h0000;
    volt = 16'h0000;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(OP_WREG, wcmd[i], wval[i], 1'b0);
      xfer(OP_RREG, rcmd[i], 8'h00, 1'b0);
      chk("usr_read", {16'h0000, rdata[7:0]}, {16'h0000, wval[i]});
    end
    chk("usr_pins", {usr1, usr2, usr3}, 24'h5A25C3);
    // host nacks the low byte here even when a checksum is asked for
    xfer(OP_MEAS, 8'hE0, 8'h00, 1'b1);
    chk("prev_t_init", rdata, 24'h000000);
    hum = 16'h0001;
    temp = 16'h5557;
    xfer(OP_MEAS, 8'hE5, 8'h00, 1'b1);
    chk("rh_hold", rdata, {16'h0002, crc8(16'h0002)});
    chk("rh_pct_lo", {16'h0000, rh_pct}, 24'h000000);
    hum = 16'hFFFF;
    temp = 16'h1235;
    xfer(OP_MEAS, 8'hF5, 8'h00, 1'b0);
    chk("rh_poll", {8'h00, rdata[15:0]}, 24'h00FFFE);
    chk("rh_pct_hi", {16'h0000, rh_pct}, 24'h000064);
    temp = 16'h0003;
    xfer(OP_MEAS, 8'hE3, 8'h00, 1'b1);
    chk("t_hold", rdata, {16'h0000, crc8(16'h0000)});
    chk("t_cc", {8'h00, temp_cc}, 24'h00EDB3);
    temp = 16'h6667;
    xfer(OP_MEAS, 8'hF3, 8'h00, 1'b0);
    chk("t_poll", {8'h00, rdata[15:0]}, 24'h006664);
    xfer(OP_MEAS, 8'hE0, 8'h00, 1'b1);
    chk("prev_t", rdata, 24'h001234);
    volt = 16'h8001;
    xfer(OP_MEAS, 8'hEE, 8'h00, 1'b1);
    chk("volt", rdata, 24'h008001);
    xfer(OP_WREG, 8'hFE, 8'h00, 1'b0);
    chk("usr_reset", {usr1, usr2, usr3}, 24'h000000);
    test_done();
  end
endmodule // humidity_temp_i2c_readout_tb
